// ---- design/pwrdn_pkg.sv ----
package pwrdn_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PDC_ONE    = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_WDT_CSR    = 8'h08;
    localparam logic [7:0] ADDR_WDT_RSTCSR = 8'h0C;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          STANDBY_SELECT_BIT = 7;
    localparam logic [7:0]  PDC_ONE_RESET      = 8'h00;
    localparam logic [7:0]  WDT_CSR_RESET      = 8'h18;
    localparam logic [7:0]  WDT_RSTCSR_RESET   = 8'h1F;
    localparam logic [7:0]  WDT_CSR_INIT_MASK  = 8'hE0;
    localparam logic [7:0]  WDT_CSR_KEEP_MASK  = 8'h1F;
    localparam logic [7:0]  WDT_RSTCSR_INIT    = 8'h1F;

    // ------------------------------------------------------------
    // Timing: sleep cycle plus five more refuse the NMI
    // ------------------------------------------------------------
    localparam int          NMI_BLOCK_AFTER    = 5;
    localparam logic [2:0]  NMI_BLOCK_CYCLES   = 3'(NMI_BLOCK_AFTER + 1);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_RUN     = 2'h0,
        ST_SLEEP   = 2'h1,
        ST_STANDBY = 2'h2
    } pd_state_t;

    typedef struct packed
    {
        logic wdt;
        logic free_timer;
        logic fifo_serial;
        logic net_dma;
        logic net_mac;
    } periph_init_t;

    typedef struct packed
    {
        logic irq;
        logic dma_err;
        logic nmi;
    } exc_start_t;

endpackage : pwrdn_pkg

// ---- design/pin_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_sync3
#(
    parameter logic RESET_LEVEL = 1'b0
)
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output var  logic level,
    output var  logic rise,
    output var  logic fall
);

    logic s1;
    logic s2;
    logic s3;
    logic agree;

    // ------------------------------------------------------------
    // Three stages; only the second and third are compared
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1 <= RESET_LEVEL;
            s2 <= RESET_LEVEL;
            s3 <= RESET_LEVEL;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Level moves only once the late stages agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            level <= RESET_LEVEL;
        else if (agree)
            level <= s2;
    end

    // Edges are one-cycle pulses on the accepted change
    always_comb
    begin
        agree = (s2 == s3);
        rise  = agree && s2 && !level;
        fall  = agree && !s2 && level;
    end

endmodule : pin_sync3

`default_nettype wire

// ---- design/sleep_standby_power_down_control.sv ----
// Behaviour
// - Sleep instruction, select clear: enter sleep
// - Peripherals keep clocking during sleep
// - Sleep ends: interrupt, DMA error, resets
// - Wake only on unmasked, enabled interrupts
// - DMA address error wakes, starts handling
// - Refuse NMI for sleep cycle plus five
// - Standby stops CPU and peripheral clocks
// - Standby keeps retained peripheral register state
// - Watchdog: init bits 7-5, reset register
// - Standby initializes timer, serial, network blocks
// - Standby ends: NMI edge or resets only
`timescale 1ns/1ps
`default_nettype none

module sleep_standby_power_down_control
    import pwrdn_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output var  logic         pready,
    output var  logic [31:0]  prdata,
    output var  logic         pslverr,
    // CPU core and interrupt controller
    input  wire logic         sleep_exec,
    input  wire logic         irq_req,
    input  wire logic [3:0]   irq_level,
    input  wire logic         irq_enabled,
    input  wire logic [3:0]   cpu_status_mask,
    input  wire logic         dma_addr_err,
    input  wire logic         nmi_rising_sel,
    // Pins
    input  wire logic         nmi_pin,
    input  wire logic         manual_reset_n,
    // Clock gates and peripheral control
    output var  logic         cpu_clk_en,
    output var  logic         periph_clk_en,
    output var  logic         cpu_halt,
    output var  periph_init_t periph_init,
    output var  exc_start_t   exc_start,
    output var  logic         manual_reset_wake
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pd_state_t   state;
    pd_state_t   next_state;
    logic [7:0]  pdc_one;
    logic [7:0]  wdt_csr;
    logic [7:0]  wdt_rstcsr;
    logic [2:0]  nmi_block_cnt;
    logic        nmi_rise;
    logic        nmi_fall;
    logic        nmi_edge;
    logic        mrst_fall;
    logic        irq_ok;
    logic        enter_sleep;
    logic        enter_standby;
    logic        nmi_take;
    logic        apb_write;
    logic        apb_read;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_sync3 #(.RESET_LEVEL(1'b0)) u_nmi_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (nmi_pin),
        .level   (),
        .rise    (nmi_rise),
        .fall    (nmi_fall)
    );

    pin_sync3 #(.RESET_LEVEL(1'b1)) u_mrst_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (manual_reset_n),
        .level   (),
        .rise    (),
        .fall    (mrst_fall)
    );

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    always_comb
    begin
        nmi_edge  = nmi_rising_sel ? nmi_rise : nmi_fall;
        // Priority must exceed the mask and the source be enabled
        irq_ok    = irq_req && irq_enabled && (irq_level > cpu_status_mask);
        // NMI refused in the sleep cycle and the window after it
        nmi_take  = nmi_edge && (nmi_block_cnt == 3'h0)
                    && !(sleep_exec && state == ST_RUN);
        // Select bit is sampled as the instruction executes
        enter_sleep   = sleep_exec && (state == ST_RUN)
                        && !pdc_one[STANDBY_SELECT_BIT];
        enter_standby = sleep_exec && (state == ST_RUN)
                        && pdc_one[STANDBY_SELECT_BIT];
        // Writes land on the edge that completes the transfer
        apb_write = psel && penable && pwrite && pready;
        apb_read  = psel && penable && !pwrite && !pready;
    end

    // ------------------------------------------------------------
    // NMI refusal window counter
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nmi_block_cnt <= 3'h0;
        else if (sleep_exec && state == ST_RUN)
            nmi_block_cnt <= 3'(NMI_BLOCK_AFTER);
        else if (nmi_block_cnt != 3'h0)
            nmi_block_cnt <= nmi_block_cnt - 3'h1;
    end

    // ------------------------------------------------------------
    // Power-down state machine
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN:
            begin
                if (enter_standby)
                    next_state = ST_STANDBY;
                else if (enter_sleep)
                    next_state = ST_SLEEP;
            end
            ST_SLEEP:
            begin
                // Any of the wake events returns to execution
                if (irq_ok || dma_addr_err || nmi_take || mrst_fall)
                    next_state = ST_RUN;
            end
            ST_STANDBY:
            begin
                // Ordinary interrupts and DMA errors are ignored here
                if (nmi_take || mrst_fall)
                    next_state = ST_RUN;
            end
            default:
                next_state = ST_RUN;
        endcase
    end

    // Power-on reset (presetn) cancels either mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // Clock gates; outputs registered from next_state, in step with state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_clk_en    <= 1'b1;
            periph_clk_en <= 1'b1;
            cpu_halt      <= 1'b0;
        end
        else
        begin
            // CPU halts at once; its registers simply hold
            cpu_halt      <= (next_state != ST_RUN);
            cpu_clk_en    <= (next_state == ST_RUN);
            // Sleep leaves peripherals running, standby stops them
            periph_clk_en <= (next_state != ST_STANDBY);
        end
    end

    // ------------------------------------------------------------
    // Peripheral initialisation on standby entry
    // ------------------------------------------------------------
    // Interrupt, break, bus, serial I/O, debug, pulse timer and pin
    // function blocks get no init line, so they keep their state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            periph_init <= '0;
        else
        begin
            periph_init.wdt         <= enter_standby;
            periph_init.free_timer  <= enter_standby;
            periph_init.fifo_serial <= enter_standby;
            periph_init.net_dma     <= enter_standby;
            periph_init.net_mac     <= enter_standby;
        end
    end

    // ------------------------------------------------------------
    // Exception start pulses and reset wake
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exc_start         <= '0;
            manual_reset_wake <= 1'b0;
        end
        else
        begin
            exc_start.irq     <= (state == ST_SLEEP) && irq_ok
                                 && !dma_addr_err && !nmi_take;
            exc_start.dma_err <= (state == ST_SLEEP) && dma_addr_err;
            // NMI is served in any state once outside the window and without a manual reset fall
            exc_start.nmi     <= nmi_take && !mrst_fall;
            manual_reset_wake <= mrst_fall && (state != ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // Registers: control and watchdog shadow
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pdc_one <= PDC_ONE_RESET;
        else if (apb_write && paddr == ADDR_PDC_ONE)
            pdc_one <= pwdata[7:0];
    end

    // Standby entry beats a write in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdt_csr    <= WDT_CSR_RESET;
            wdt_rstcsr <= WDT_RSTCSR_RESET;
        end
        else if (enter_standby)
        begin
            wdt_csr    <= (wdt_csr & WDT_CSR_KEEP_MASK)
                          | (WDT_CSR_RESET & WDT_CSR_INIT_MASK);
            wdt_rstcsr <= WDT_RSTCSR_INIT;
        end
        else if (apb_write && paddr == ADDR_WDT_CSR)
            wdt_csr <= pwdata[7:0];
        else if (apb_write && paddr == ADDR_WDT_RSTCSR)
            wdt_rstcsr <= pwdata[7:0];
    end

    // ------------------------------------------------------------
    // APB answer: one wait state, registered data and error
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready)
            begin
                case (paddr)
                    ADDR_PDC_ONE:    prdata <= {24'h000000, pdc_one};
                    ADDR_STATUS:     prdata <= {30'h0, state};
                    ADDR_WDT_CSR:    prdata <= {24'h000000, wdt_csr};
                    ADDR_WDT_RSTCSR: prdata <= {24'h000000, wdt_rstcsr};
                    default:         pslverr <= 1'b1;
                endcase
                // Status is read-only; a write to it is an error
                if (pwrite && paddr == ADDR_STATUS)
                    pslverr <= 1'b1;
                if (!apb_read)
                    prdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_sleep_entry;
        enter_sleep |=> (state == ST_SLEEP) && cpu_halt && !cpu_clk_en;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep not entered");

    property p_sleep_periph;
        state == ST_SLEEP |-> periph_clk_en && !cpu_clk_en;
    endproperty
    a_sleep_periph: assert property (p_sleep_periph)
        else $error("peripheral clock wrong in sleep");

    property p_sleep_mrst;
        (state == ST_SLEEP) && mrst_fall |=> (state == ST_RUN) && manual_reset_wake;
    endproperty
    a_sleep_mrst: assert property (p_sleep_mrst)
        else $error("manual reset did not cancel sleep");

    property p_irq_masked;
        (state == ST_SLEEP) && !irq_ok && !dma_addr_err && !nmi_take && !mrst_fall
            |=> state == ST_SLEEP && !exc_start.irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("left sleep without a wake event");

    property p_dma_wake;
        (state == ST_SLEEP) && dma_addr_err |=> exc_start.dma_err ##1 cpu_clk_en;
    endproperty
    a_dma_wake: assert property (p_dma_wake)
        else $error("dma error did not wake");

    property p_nmi_block;
        sleep_exec && (state == ST_RUN) |=> !exc_start.nmi [*6];
    endproperty
    a_nmi_block: assert property (p_nmi_block)
        else $error("nmi accepted in refusal window");

    property p_standby_clk;
        state == ST_STANDBY |-> !cpu_clk_en && !periph_clk_en;
    endproperty
    a_standby_clk: assert property (p_standby_clk)
        else $error("clock running in standby");

    property p_wdt_init;
        enter_standby |=> wdt_csr[7:5] == WDT_CSR_RESET[7:5]
            && wdt_csr[2:0] == $past(wdt_csr[2:0]) && wdt_rstcsr == WDT_RSTCSR_INIT;
    endproperty
    a_wdt_init: assert property (p_wdt_init)
        else $error("watchdog fields wrong after standby entry");

    property p_init_pulse;
        enter_standby |=> (periph_init == '1) ##1 (periph_init == '0);
    endproperty
    a_init_pulse: assert property (p_init_pulse)
        else $error("init pulse wrong");

    property p_standby_hold;
        (state == ST_STANDBY) && !nmi_take && !mrst_fall |=> state == ST_STANDBY;
    endproperty
    a_standby_hold: assert property (p_standby_hold)
        else $error("standby left without nmi or reset");

endmodule : sleep_standby_power_down_control

`default_nettype wire

// ---- verif/cpu_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// CPU core and interrupt side of the power-down block
// ----------------------------------------------------------------
module cpu_core_model
(
    input  wire logic       pclk,
    output var  logic       sleep_exec,
    output var  logic       irq_req,
    output var  logic [3:0] irq_level,
    output var  logic       irq_enabled,
    output var  logic [3:0] cpu_status_mask,
    output var  logic       dma_addr_err,
    output var  logic       nmi_rising_sel,
    output var  logic       nmi_pin,
    output var  logic       manual_reset_n
);
    // Quiet at start; rising NMI edges are the ones that count
    initial
    begin
        sleep_exec     = 1'b0;
        irq_req        = 1'b0;
        irq_level      = 4'h0;
        irq_enabled    = 1'b0;
        cpu_status_mask = 4'hF;
        dma_addr_err   = 1'b0;
        nmi_rising_sel = 1'b1;
        nmi_pin        = 1'b0;
        manual_reset_n = 1'b1;
    end

    // Sleep instruction lasts exactly one cycle
    task automatic do_sleep();
        @(posedge pclk) sleep_exec <= 1'b1;
        @(posedge pclk) sleep_exec <= 1'b0;
    endtask : do_sleep

    // Interrupt held a few cycles, then withdrawn like an acked source
    task automatic irq(input logic [3:0] lvl, input logic [3:0] msk, input logic en);
        @(posedge pclk);
        irq_req     <= 1'b1;
        irq_level   <= lvl;
        cpu_status_mask <= msk;
        irq_enabled <= en;
        repeat (4) @(posedge pclk);
        irq_req     <= 1'b0;
    endtask : irq

    // Address error reported for one cycle
    task automatic dma_err();
        @(posedge pclk) dma_addr_err <= 1'b1;
        @(posedge pclk) dma_addr_err <= 1'b0;
    endtask : dma_err

    // Pin levels; the block synchronises them itself
    task automatic pin_nmi(input logic v);
        @(posedge pclk) nmi_pin <= v;
    endtask : pin_nmi

    // Edge polarity that the block counts on the NMI pin
    task automatic nmi_sel(input logic v);
        @(posedge pclk) nmi_rising_sel <= v;
    endtask : nmi_sel

    task automatic pin_mreset();
        @(posedge pclk) manual_reset_n <= 1'b0;
        repeat (4) @(posedge pclk);
        manual_reset_n <= 1'b1;
    endtask : pin_mreset
endmodule : cpu_core_model

`default_nettype wire

// ---- verif/sleep_standby_power_down_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module sleep_standby_power_down_control_bench;
    import pwrdn_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic rerr, cpu_clk_en, periph_clk_en, cpu_halt, manual_reset_wake, seen_mrw;
    logic sleep_exec, irq_req, irq_enabled, dma_addr_err, nmi_rising_sel;
    logic nmi_pin, manual_reset_n;
    logic [3:0] irq_level, cpu_status_mask;
    periph_init_t periph_init;
    exc_start_t   exc_start;
    logic [4:0] seen_init;
    logic [2:0] seen_exc;
    int num_errors = 0;
    int cmp_count  = 0;
    logic [7:0] ra[4] = '{ADDR_PDC_ONE, ADDR_STATUS, ADDR_WDT_CSR, ADDR_WDT_RSTCSR};
    logic [7:0] rv[4] = '{PDC_ONE_RESET, 8'h00, WDT_CSR_RESET, WDT_RSTCSR_RESET};
    logic [3:0] lv[3] = '{4'h5, 4'h4, 4'h6};
    logic       en[3] = '{1'b1, 1'b1, 1'b0};

    // ------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    sleep_standby_power_down_control DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .sleep_exec(sleep_exec), .irq_req(irq_req), .irq_level(irq_level),
        .irq_enabled(irq_enabled), .cpu_status_mask(cpu_status_mask),
        .dma_addr_err(dma_addr_err), .nmi_rising_sel(nmi_rising_sel), .nmi_pin(nmi_pin),
        .manual_reset_n(manual_reset_n), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .cpu_halt(cpu_halt),
        .periph_init(periph_init), .exc_start(exc_start),
        .manual_reset_wake(manual_reset_wake));

    cpu_core_model cpu (.pclk(pclk), .sleep_exec(sleep_exec), .irq_req(irq_req),
        .irq_level(irq_level), .irq_enabled(irq_enabled), .cpu_status_mask(cpu_status_mask),
        .dma_addr_err(dma_addr_err), .nmi_rising_sel(nmi_rising_sel),
        .nmi_pin(nmi_pin), .manual_reset_n(manual_reset_n));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never completes
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Collects one-cycle pulses, since they stand a single cycle only
    task automatic watch(input int n);
        seen_exc  = 3'h0;
        seen_init = 5'h00;
        seen_mrw  = 1'b0;
        repeat (n)
        begin
            @(posedge pclk);
            seen_exc  |= exc_start;
            seen_init |= periph_init;
            seen_mrw  |= manual_reset_wake;
        end
    endtask : watch

    task automatic go_sleep();
        fork
            cpu.do_sleep();
            watch(3);
        join
    endtask : go_sleep

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            check(rdata, {24'h0, rv[i]});
        end
        apb(1'b0, 8'h10, 32'h0);
        check({rdata[30:0], rerr}, 32'h1);
        apb(1'b1, ADDR_STATUS, 32'h1);
        check(rerr, 1'b1);
        // Sleep: CPU stops, peripherals keep running
        go_sleep();
        check({cpu_halt, cpu_clk_en, periph_clk_en}, 3'b101);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rdata, 32'h1);
        // Level equal to mask, below it, or disabled: no wake
        for (int i = 0; i < 3; i++)
        begin
            fork
                cpu.irq(lv[i], 4'h5, en[i]);
                watch(8);
            join
            check({seen_exc, cpu_halt}, 4'h1);
        end
        fork
            cpu.irq(4'h6, 4'h5, 1'b1);
            watch(8);
        join
        check({seen_exc, cpu_clk_en}, 4'h9);
        go_sleep();
        fork
            cpu.dma_err();
            watch(4);
        join
        check({seen_exc, cpu_halt}, 4'h4);
        go_sleep();
        fork
            cpu.pin_mreset();
            watch(12);
        join
        check({seen_mrw, cpu_halt}, 2'b10);
        go_sleep();
        @(posedge pclk) presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        @(posedge pclk);
        check({cpu_halt, cpu_clk_en}, 2'b01);
        // Standby with an NMI edge inside the refusal window
        apb(1'b1, ADDR_WDT_CSR, 32'hFF);
        apb(1'b1, ADDR_WDT_RSTCSR, 32'h00);
        apb(1'b1, ADDR_PDC_ONE, 32'h80);
        fork
            cpu.do_sleep();
            cpu.pin_nmi(1'b1);
            watch(10);
        join
        check({seen_exc, seen_init}, 8'h1F);
        check({cpu_halt, cpu_clk_en, periph_clk_en}, 3'b100);
        apb(1'b0, ADDR_WDT_CSR, 32'h0);
        check(rdata, 32'h1F);
        apb(1'b0, ADDR_WDT_RSTCSR, 32'h0);
        check(rdata, 32'h1F);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rdata, 32'h2);
        // Interrupt, DMA error and an uncounted NMI edge leave standby alone
        fork
            cpu.irq(4'h9, 4'h0, 1'b1);
            cpu.dma_err();
            cpu.pin_nmi(1'b0);
            watch(10);
        join
        check({seen_exc, cpu_halt}, 4'h1);
        fork
            cpu.pin_nmi(1'b1);
            watch(10);
        join
        check({seen_exc, cpu_clk_en, periph_clk_en}, 5'h07);
        // Falling-edge selection: the next standby ends on a falling NMI edge
        cpu.nmi_sel(1'b0);
        go_sleep();
        repeat (4) @(posedge pclk);
        check({cpu_halt, periph_clk_en}, 2'b10);
        fork
            cpu.pin_nmi(1'b0);
            watch(10);
        join
        check({seen_exc, cpu_halt, periph_clk_en}, 5'h05);
        conclude();
    end

    // Run needs under two hundred cycles; cut off far beyond that
    initial
    begin
        #75000;
        num_errors++;
        conclude();
    end
endmodule : sleep_standby_power_down_control_bench

`default_nettype wire
